// *** tb.sv ***
// Self-checking bench for the watchdog block
`timescale 1ns/1ns
module tb;
    import wdt_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [ADR_W-1:0] adr_i = '0;
    logic [31:0] dat_i = '0;
    logic [3:0] sel_i = '0;
    logic we_i = 1'b0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic awake_i = 1'b0;
    logic [31:0] dat_o;
    logic ack_o;
    logic err_o;
    logic tile_reset_o;
    logic [OSC_MHZ_W-1:0] osc_mhz_o;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    logic [15:0] tmo;
    int num_errors = 0;
    int n_tests = 0;
    int i;
    int n;
    // Short tick: 2 cycles per MHz keeps each millisecond tiny
    wdt_clock_setting #(.CYC_PER_MHZ(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
        .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .awake_i(awake_i),
        .tile_reset_o(tile_reset_o), .osc_mhz_o(osc_mhz_o));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        n_tests++;
        if (seen !== want) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // Expectation is {compare data, err, data}; starts and ends on a rising edge
    task automatic wb(input logic [7:0] idx, input logic w, input logic [31:0] d,
                      input logic [3:0] s, input logic [33:0] x);
        int k;
        exp_q.push_back(x);
        adr_i <= {idx, 2'b00};
        we_i <= w;
        dat_i <= d;
        sel_i <= s;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1 || err_o === 1'b1) break;
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        if (k == 20) begin
            num_errors++;
            end_of_test();
        end
        @(posedge clk_i);
    endtask : wb
    task automatic rd(input logic [7:0] idx, input logic [31:0] d);
        wb(idx, 1'b0, 32'h0, 4'hf, {2'b10, d});
    endtask : rd
    task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic er);
        wb(idx, 1'b1, d, 4'hf, {1'b0, er, 32'h0});
    endtask : wr
    // Answers are taken oldest note first
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 || err_o === 1'b1) begin
            e = exp_q.pop_front();
            check({err_o, e[33] ? dat_o : 32'h0}, e[32:0]);
        end
    end
    initial begin
        i = $urandom(25);
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(REG_IDX_OSC, 32'h0000_0019);
        rd(REG_IDX_WDT, 32'h0000_03e8);
        rd(REG_IDX_DIS, 32'h0d15_ab1e);
        wb(8'h10, 1'b0, 32'h0, 4'hf, {2'b01, 32'h0});
        $display("test reset values done");
        wr(REG_IDX_OSC, 32'h0000_0004, 1'b1);
        wr(REG_IDX_OSC, 32'h0000_0065, 1'b1);
        wr(REG_IDX_OSC, 32'h0000_0064, 1'b0);
        rd(REG_IDX_OSC, 32'h0000_0064);
        check(33'(osc_mhz_o), 33'h64);
        wb(REG_IDX_OSC, 1'b1, 32'h7, 4'h7, {2'b01, 32'h0});
        wr(REG_IDX_OSC, 32'h0000_0005, 1'b0);
        rd(REG_IDX_OSC, 32'h0000_0005);
        $display("test frequency range done");
        // At least three ticks, so a second expiry cannot stretch the tile reset
        tmo = 16'h0003 + 16'($urandom_range(3));
        wr(REG_IDX_WDT, {~tmo ^ 16'h0100, tmo}, 1'b1);
        wr(REG_IDX_WDT, {~tmo, tmo}, 1'b0);
        wr(REG_IDX_DIS, DIS_ENABLE, 1'b0);
        repeat (40) @(posedge clk_i);
        // Asleep: the count must not move
        rd(REG_IDX_WDT, {tmo, tmo});
        $display("test enable while asleep done");
        awake_i <= 1'b1;
        for (i = 0; i < 200 && tile_reset_o !== 1'b1; i++) begin
            @(posedge clk_i);
        end
        check(33'(i > (tmo - 1) * 10 && i <= tmo * 10 + 4), 33'h1);
        for (n = 0; n < 100 && tile_reset_o === 1'b1; n++) begin
            @(posedge clk_i);
        end
        check(33'(n), 33'(TILE_RST_CYC));
        $display("test expiry done");
        awake_i <= 1'b0;
        rd(REG_IDX_EVT, 32'h0000_0001);
        wr(REG_IDX_EVT, 32'h0000_0001, 1'b0);
        rd(REG_IDX_EVT, 32'h0000_0000);
        wr(REG_IDX_WDT, 32'hffbf_0040, 1'b0);
        repeat (2) @(posedge clk_i);
        rd(REG_IDX_WDT, 32'h0040_0040);
        wr(REG_IDX_DIS, DIS_KEY, 1'b0);
        repeat (2) @(posedge clk_i);
        rd(REG_IDX_WDT, 32'h0000_0040);
        rd(REG_IDX_DIS, 32'h0d15_ab1e);
        $display("test kick and disable done");
        end_of_test();
    end
endmodule : tb

// *** wdt_clock_setting.sv ***
// Watchdog with oscillator frequency setting, behind a Wishbone slave
`timescale 1ns/1ns
module wdt_clock_setting #(
    parameter int CYC_PER_MHZ = wdt_pkg::CYC_PER_MHZ_TICK
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic [wdt_pkg::ADR_W-1:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // Power state and reset out
    input wire logic awake_i,
    output logic tile_reset_o,
    // Frequency for other consumers
    output logic [wdt_pkg::OSC_MHZ_W-1:0] osc_mhz_o
);
    import wdt_pkg::*;

    // Registers
    logic [OSC_MHZ_W-1:0] osc_mhz_r;
    logic [TMO_W-1:0] timeout_r;
    logic [31:0] disable_r;
    logic expired_r;

    // Bus response
    logic ack_r;
    logic err_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // Decode
    logic [7:0] idx;
    logic req;
    logic done;
    logic hit_osc;
    logic hit_wdt;
    logic hit_dis;
    logic hit_evt;
    logic known;
    logic full_sel;
    logic osc_ok;
    logic tmo_ok;
    logic wr_ok;
    logic wr_go;

    // Watchdog core
    logic tick;
    logic run;
    logic load_r;
    logic expire;
    logic [TMO_W-1:0] count;
    logic [TRST_W-1:0] trst_cnt_r;

    assign idx = adr_i[IDX_LSB+7:IDX_LSB];
    assign req = cyc_i && stb_i && !ack_r && !err_r;
    assign done = cyc_i && stb_i && ack_r;

    assign hit_osc = (idx == REG_IDX_OSC);
    assign hit_wdt = (idx == REG_IDX_WDT);
    assign hit_dis = (idx == REG_IDX_DIS);
    assign hit_evt = (idx == REG_IDX_EVT);
    assign known = hit_osc || hit_wdt || hit_dis || hit_evt;

    // Partial writes would split the complement check, so refuse them
    assign full_sel = &sel_i;

    assign osc_ok = (dat_i[OSC_MHZ_W-1:0] >= OSC_MHZ_MIN) &&
                    (dat_i[OSC_MHZ_W-1:0] <= OSC_MHZ_MAX);

    assign tmo_ok = (dat_i[CMP_LSB+TMO_W-1:CMP_LSB] ==
                     ~dat_i[TMO_LSB+TMO_W-1:TMO_LSB]);

    always_comb begin
        wr_ok = full_sel;
        if (hit_osc) begin
            wr_ok = full_sel && osc_ok;
        end else if (hit_wdt) begin
            wr_ok = full_sel && tmo_ok;
        end
    end

    // Write lands on the edge where the master sees ack
    assign wr_go = done && we_i;

    // Bus answer one cycle after the request is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && known && (!we_i || wr_ok);
        end
    end

    // Unmapped and refused writes answer with err
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_r <= 1'b0;
        end else begin
            err_r <= req && !(known && (!we_i || wr_ok));
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (1'b1)
            hit_osc: begin
                rdata_nxt[OSC_MHZ_LSB+OSC_MHZ_W-1:OSC_MHZ_LSB] = osc_mhz_r;
            end
            hit_wdt: begin
                rdata_nxt[CNT_LSB+TMO_W-1:CNT_LSB] = count;
                rdata_nxt[TMO_LSB+TMO_W-1:TMO_LSB] = timeout_r;
            end
            hit_dis: begin
                rdata_nxt = disable_r;
            end
            hit_evt: begin
                rdata_nxt[EVT_EXPIRED_BIT] = expired_r;
            end
            default: begin
                rdata_nxt = 32'h0000_0000;
            end
        endcase
    end

    // Snapshot taken with the request, stable while ack is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (req && !we_i) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign dat_o = rdata_r;
    assign ack_o = ack_r;
    assign err_o = err_r;

    // Oscillator frequency setting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_mhz_r <= OSC_MHZ_RST;
        end else if (wr_go && hit_osc) begin
            osc_mhz_r <= dat_i[OSC_MHZ_LSB+OSC_MHZ_W-1:OSC_MHZ_LSB];
        end
    end

    assign osc_mhz_o = osc_mhz_r;

    // Timeout value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timeout_r <= TMO_RST;
        end else if (wr_go && hit_wdt) begin
            timeout_r <= dat_i[TMO_LSB+TMO_W-1:TMO_LSB];
        end
    end

    // Disable key; only an exact zero lets the watchdog run
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            disable_r <= DIS_KEY;
        end else if (wr_go && hit_dis) begin
            disable_r <= dat_i;
        end
    end

    assign run = (disable_r == DIS_ENABLE);

    // Reload on a kick, or when enabling from a stopped state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_r <= 1'b0;
        end else begin
            load_r <= wr_go && (hit_wdt ||
                      (hit_dis && dat_i == DIS_ENABLE));
        end
    end

    wdt_ms_tick #(
        .CYC_PER_MHZ(CYC_PER_MHZ)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mhz_i(osc_mhz_r),
        .tick_o(tick)
    );

    wdt_countdown u_count (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(run),
        .load_i(load_r),
        .awake_i(awake_i),
        .tick_i(tick),
        .timeout_i(timeout_r),
        .count_o(count),
        .expire_o(expire)
    );

    // Sticky expiry record; a new expiry beats a clearing write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            expired_r <= 1'b0;
        end else if (expire) begin
            expired_r <= 1'b1;
        end else if (wr_go && hit_evt && dat_i[EVT_EXPIRED_BIT]) begin
            expired_r <= 1'b0;
        end
    end

    // Tile reset held for a fixed number of cycles after expiry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trst_cnt_r <= '0;
        end else if (expire) begin
            trst_cnt_r <= TRST_W'(TILE_RST_CYC);
        end else if (trst_cnt_r != '0) begin
            trst_cnt_r <= trst_cnt_r - TRST_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tile_reset_o <= 1'b0;
        end else begin
            tile_reset_o <= expire || (trst_cnt_r > TRST_W'(1));
        end
    end

endmodule : wdt_clock_setting

// *** wdt_clock_setting_checker.sv ***
// Port assertions for the watchdog block
`timescale 1ns/1ns
module wdt_clock_setting_checker import wdt_pkg::*; (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic err_o,
    // Outputs
    input wire logic tile_reset_o,
    input wire logic [OSC_MHZ_W-1:0] osc_mhz_o
);
    logic [7:0] len_r;
    wire take = cyc_i && stb_i && !ack_o && !err_o;
    wire [7:0] idx = adr_i[9:2];
    wire wr = take && we_i && sel_i == 4'hf;
    wire osc_ok = dat_i[6:0] >= OSC_MHZ_MIN && dat_i[6:0] <= OSC_MHZ_MAX;
    wire cmp_ok = dat_i[31:16] == ~dat_i[15:0];
    wire [6:0] osc_d = dat_i[6:0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Length of the current tile reset pulse
    always_ff @(posedge clk_i) begin
        if (rst_i || !tile_reset_o) begin
            len_r <= 8'h00;
        end else begin
            len_r <= len_r + 8'h01;
        end
    end
    a_answer_next: assert property (take |=> ack_o ^ err_o) else $error("no single answer");
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held too long");
    a_osc_in_range: assert property (osc_mhz_o >= OSC_MHZ_MIN && osc_mhz_o <= OSC_MHZ_MAX)
        else $error("frequency out of range");
    a_osc_refused: assert property (wr && idx == REG_IDX_OSC && !osc_ok |=>
        err_o && $stable(osc_mhz_o) ##1 $stable(osc_mhz_o) ##1 $stable(osc_mhz_o))
        else $error("bad frequency taken");
    // Write lands at the ack edge, so the new value shows two edges after the take
    a_osc_stored: assert property (wr && idx == REG_IDX_OSC && osc_ok |=>
        ##1 osc_mhz_o == $past(osc_d, 2)) else $error("frequency not stored");
    a_tmo_bad_nack: assert property (wr && idx == REG_IDX_WDT && !cmp_ok |=> err_o)
        else $error("bad complement not refused");
    a_tmo_good_ack: assert property (wr && idx == REG_IDX_WDT && cmp_ok |=> ack_o)
        else $error("good timeout not acknowledged");
    a_tile_pulse_len: assert property ($fell(tile_reset_o) |-> len_r == TILE_RST_CYC)
        else $error("tile reset pulse length wrong");
    c_kick: cover property (wr && idx == REG_IDX_WDT && cmp_ok);
    c_expire: cover property ($rose(tile_reset_o));
    c_refused: cover property (err_o);
endmodule : wdt_clock_setting_checker

bind wdt_clock_setting wdt_clock_setting_checker chk (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .err_o(err_o), .tile_reset_o(tile_reset_o), .osc_mhz_o(osc_mhz_o));

// *** wdt_countdown.sv ***
// Watchdog down-counter with reload and expiry pulse
`timescale 1ns/1ns
module wdt_countdown (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic run_i,
    input wire logic load_i,
    input wire logic awake_i,
    input wire logic tick_i,
    input wire logic [wdt_pkg::TMO_W-1:0] timeout_i,
    // Status
    output logic [wdt_pkg::TMO_W-1:0] count_o,
    output logic expire_o
);
    import wdt_pkg::*;

    logic step;

    // Counts only in the awake power state
    assign step = tick_i && awake_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= CNT_RST;
        end else if (!run_i) begin
            count_o <= CNT_RST;
        end else if (load_i) begin
            count_o <= timeout_i;
        end else if (step) begin
            if (count_o <= TMO_W'(1)) begin
                count_o <= timeout_i;
            end else begin
                count_o <= count_o - TMO_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            expire_o <= 1'b0;
        end else begin
            expire_o <= run_i && !load_i && step && (count_o <= TMO_W'(1));
        end
    end

endmodule : wdt_countdown

// *** wdt_ms_tick.sv ***
// Millisecond tick prescaler scaled by the programmed oscillator frequency
`timescale 1ns/1ns
module wdt_ms_tick #(
    parameter int CYC_PER_MHZ = wdt_pkg::CYC_PER_MHZ_TICK
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Setting and tick
    input wire logic [wdt_pkg::OSC_MHZ_W-1:0] mhz_i,
    output logic tick_o
);
    import wdt_pkg::*;

    logic [31:0] prod;
    logic [PRE_W-1:0] limit;
    logic [PRE_W-1:0] pre_r;

    // Wrong setting scales the tick, and so the whole timeout
    assign prod = 32'(mhz_i) * 32'(CYC_PER_MHZ);
    assign limit = prod[PRE_W-1:0] - PRE_W'(1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_r <= '0;
        end else if (pre_r >= limit) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + PRE_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= (pre_r >= limit);
        end
    end

endmodule : wdt_ms_tick

// *** wdt_pkg.sv ***
// Constants shared by the watchdog and oscillator-setting block
package wdt_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] REG_IDX_OSC = 8'h51;
    localparam logic [7:0] REG_IDX_WDT = 8'hd6;
    localparam logic [7:0] REG_IDX_DIS = 8'hd7;
    localparam logic [7:0] REG_IDX_EVT = 8'hd8;
    localparam int ADR_W = 10;
    localparam int IDX_LSB = 2;

    // Oscillator frequency field
    localparam int OSC_MHZ_LSB = 0;
    localparam int OSC_MHZ_W = 7;
    localparam logic [6:0] OSC_MHZ_RST = 7'h19;
    localparam logic [6:0] OSC_MHZ_MIN = 7'h05;
    localparam logic [6:0] OSC_MHZ_MAX = 7'h64;

    // Timeout and count fields
    localparam int TMO_W = 16;
    localparam int TMO_LSB = 0;
    localparam int CMP_LSB = 16;
    localparam int CNT_LSB = 16;
    localparam logic [15:0] TMO_RST = 16'h03e8;
    localparam logic [15:0] CNT_RST = 16'h0000;

    // Disable register
    localparam logic [31:0] DIS_KEY = 32'h0d15ab1e;
    localparam logic [31:0] DIS_ENABLE = 32'h0000_0000;

    // Event register
    localparam int EVT_EXPIRED_BIT = 0;

    // Timing: one tick is one millisecond of oscillator cycles
    localparam int TICK_US = 1000;
    localparam int CYC_PER_MHZ_TICK = TICK_US;
    localparam int PRE_W = 17;

    // Tile reset pulse driven out on expiry
    localparam int CLK_MHZ = 25;
    localparam int TILE_RST_US = 1;
    localparam int TILE_RST_CYC = TILE_RST_US * CLK_MHZ;
    localparam int TRST_W = 6;

endpackage : wdt_pkg
